/* design/ces_pkg.sv */
// Shared constants and types of the exception sequencer.
package ces_pkg;
  localparam logic [3:0] RA_VBR = 4'h0;
  localparam logic [3:0] RA_CCR = 4'h1;
  localparam logic [3:0] RA_EXR = 4'h2;
  localparam logic [3:0] RA_MODE = 4'h3;
  localparam logic [3:0] RA_HALTA = 4'h4;
  localparam logic [3:0] RA_HALTB = 4'h5;
  localparam logic [3:0] RA_XFER = 4'h6;
  localparam logic [3:0] RA_STAT = 4'h7;
  localparam logic [31:0] VBR_RST = 32'h0000_0000;
  localparam logic [15:0] HALTA_RST = 16'h0fff;
  localparam logic [15:0] HALTB_RST = 16'hffff;
  localparam int EXR_T = 7;
  localparam int CCR_I = 7;
  localparam int XFER_ERR = 7;
  localparam logic [2:0] MASK_MAX = 3'h7;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE2 = 2'h2;
  localparam logic [31:0] VO_RESET = 32'h0000_0000;
  localparam logic [31:0] VO_TRACE = 32'h0000_0014;
  localparam logic [31:0] VO_ADDR_ERR = 32'h0000_0030;
  localparam logic [31:0] STK_PC_OFS = 32'h0000_0004;
  localparam logic [31:0] STK_SR_OFS = 32'h0000_0008;
  localparam logic [23:0] PERIPH_LO = 24'hff_0000;
  localparam logic [23:0] PERIPH_HI = 24'hff_ffff;
  localparam logic [23:0] EXT_LO = 24'h40_0000;
  localparam logic [23:0] EXT_HI = 24'hef_ffff;
  localparam logic [23:0] PROHIB_LO = 24'hf0_0000;
  localparam logic [23:0] PROHIB_HI = 24'hfe_ffff;
  localparam int N_EXT = 12;
  localparam int N_WDT = 1;
  localparam int N_ADC = 1;
  localparam int N_PTU = 26;
  localparam int N_TMR = 12;
  localparam int N_SER = 16;
  localparam int N_PERIPH = N_WDT + N_ADC + N_PTU + N_TMR + N_SER;
  typedef enum logic [1:0] {
    CES_FETCH = 2'h0,
    CES_STACK = 2'h1,
    CES_DATA = 2'h2
  } ces_kind_t;
  typedef struct packed {
    logic valid;
    ces_kind_t kind;
    logic [23:0] addr;
  } ces_cycle_t;
  typedef struct packed {
    logic done;
    logic return_from_exception;
    logic [31:0] next_pc;
  } ces_retire_t;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_VFETCH = 3'b001,
    ST_FIRST = 3'b011,
    ST_RUN = 3'b010,
    ST_STK_PC = 3'b110,
    ST_STK_SR = 3'b111,
    ST_EVEC = 3'b101
  } ces_state_t;
endpackage : ces_pkg

/* design/ces_addr_check.sv */
// Address error classifier for one bus master.
`timescale 1ns/1ps
`default_nettype none
module ces_addr_check
  import ces_pkg::*;
(
  // Cycle under test.
  input wire ces_cycle_t cyc,
  input wire logic single_chip,
  input wire logic is_cpu,
  // Verdict.
  output logic err
);
  logic in_per;
  logic in_ext;
  logic in_pro;

  always_comb begin
    in_per = (cyc.addr >= PERIPH_LO) && (cyc.addr <= PERIPH_HI);
    in_ext = single_chip && (cyc.addr >= EXT_LO) && (cyc.addr <= EXT_HI);
    in_pro = (cyc.addr >= PROHIB_LO) && (cyc.addr <= PROHIB_HI);
    err = 1'b0;
    if (cyc.valid) begin
      case (cyc.kind)
        CES_FETCH: err = is_cpu && (cyc.addr[0] || in_per || in_ext || in_pro);
        CES_STACK: err = is_cpu && cyc.addr[0];
        CES_DATA: err = in_ext || in_pro;
        default: err = 1'b0;
      endcase
    end
  end
endmodule : ces_addr_check
`default_nettype wire

/* design/ces_sequencer.sv */
// Exception sequencer: reset, trace and address error handling.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ces_sequencer
  import ces_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pipeline and bus masters.
  input wire ces_retire_t retire,
  input wire logic [7:0] rte_ccr,
  input wire logic [7:0] rte_exr,
  input wire logic [31:0] stack_ptr,
  input wire ces_cycle_t cpu_cyc,
  input wire ces_cycle_t xfer_cyc,
  input wire logic single_chip,
  output logic pc_load,
  output logic [31:0] pc_value,
  output logic sp_load,
  output logic [31:0] sp_value,
  // Vector table and stack memory.
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Interrupt sources.
  input wire logic nmi,
  input wire logic [N_EXT-1:0] ext_int_lines,
  input wire logic [N_PERIPH-1:0] periph_int,
  output logic int_allow,
  output logic int_pending,
  // Peripheral access gate.
  input wire logic [4:0] pa_sel,
  input wire logic pa_b,
  input wire logic pa_req,
  output logic pa_grant,
  // Status seen by the core.
  output logic [7:0] cond_code_reg,
  output logic [7:0] extended_ctrl_reg,
  output logic [15:0] module_halt_ctrl_a,
  output logic [15:0] module_halt_ctrl_b,
  output logic xfer_halt
);
  ces_state_t state;
  ces_state_t next_state;
  logic [31:0] vector_base_reg;
  logic [31:0] next_vbr;
  logic [7:0] next_ccr;
  logic [7:0] next_exr;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [15:0] next_halt_a;
  logic [15:0] next_halt_b;
  logic [7:0] transfer_ctrl_reg;
  logic [7:0] next_xfer;
  logic ae_pend;
  logic next_ae_pend;
  logic [31:0] next_rdata;
  logic next_pc_load;
  logic [31:0] next_pc_value;
  logic next_sp_load;
  logic [31:0] next_sp_value;
  logic next_mem_req;
  logic next_mem_we;
  logic [31:0] next_mem_addr;
  logic [31:0] next_mem_wdata;
  logic next_int_allow;
  logic next_int_pending;
  logic next_pa_grant;
  logic [31:0] save_pc;
  logic [31:0] next_save_pc;
  logic [15:0] save_sr;
  logic [15:0] next_save_sr;
  logic [31:0] vec_addr;
  logic [31:0] next_vec_addr;
  logic cpu_err;
  logic xfer_err;
  logic any_err;
  logic do_trace;
  logic mem_done;
  logic [15:0] halt_sel;

  ces_addr_check u_cpu_chk (
    .cyc(cpu_cyc),
    .single_chip(single_chip),
    .is_cpu(1'b1),
    .err(cpu_err)
  );

  ces_addr_check u_xfer_chk (
    .cyc(xfer_cyc),
    .single_chip(single_chip),
    .is_cpu(1'b0),
    .err(xfer_err)
  );

  always_comb begin
    any_err = cpu_err || xfer_err;
    mem_done = mem_req && mem_ack;
    halt_sel = pa_b ? module_halt_ctrl_b : module_halt_ctrl_a;
    // The return instruction itself restores the flag, so it must not trap.
    do_trace = retire.done && !retire.return_from_exception && (mode == MODE2) &&
               extended_ctrl_reg[EXR_T];
  end

  always_comb begin
    next_state = state;
    next_vbr = vector_base_reg;
    next_ccr = cond_code_reg;
    next_exr = extended_ctrl_reg;
    next_mode = mode;
    next_halt_a = module_halt_ctrl_a;
    next_halt_b = module_halt_ctrl_b;
    next_xfer = transfer_ctrl_reg;
    next_ae_pend = ae_pend;
    next_rdata = reg_rdata;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_sp_load = 1'b0;
    next_sp_value = sp_value;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_int_allow = int_allow;
    next_save_pc = save_pc;
    next_save_sr = save_sr;
    next_vec_addr = vec_addr;
    next_pa_grant = pa_req && !halt_sel[pa_sel[3:0]] && !pa_sel[4];
    next_int_pending = int_allow && (nmi || (|ext_int_lines) || (|periph_int));

    if (reg_rd) begin
      case (reg_addr)
        RA_VBR: next_rdata = vector_base_reg;
        RA_CCR: next_rdata = {24'h00_0000, cond_code_reg};
        RA_EXR: next_rdata = {24'h00_0000, extended_ctrl_reg};
        RA_MODE: next_rdata = {30'h0000_0000, mode};
        RA_HALTA: next_rdata = {16'h0000, module_halt_ctrl_a};
        RA_HALTB: next_rdata = {16'h0000, module_halt_ctrl_b};
        RA_XFER: next_rdata = {24'h00_0000, transfer_ctrl_reg};
        RA_STAT: next_rdata = {27'h000_0000, int_allow, ae_pend, state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        RA_VBR: next_vbr = reg_wdata;
        RA_CCR: next_ccr = reg_wdata[7:0];
        RA_EXR: next_exr = reg_wdata[7:0];
        RA_MODE: begin
          // Only the two supported modes are stored; other codes are dropped.
          if (reg_wdata[1:0] == MODE0 || reg_wdata[1:0] == MODE2) begin
            next_mode = reg_wdata[1:0];
          end
        end
        RA_HALTA: next_halt_a = reg_wdata[15:0];
        RA_HALTB: next_halt_b = reg_wdata[15:0];
        RA_XFER: next_xfer = reg_wdata[7:0];
        default: next_xfer = next_xfer;
      endcase
    end

    if (retire.done && retire.return_from_exception) begin
      next_ccr = rte_ccr;
      next_exr = rte_exr;
    end

    // Errors latch as pending only in ST_RUN or ST_FIRST; faults in other states, stacking included, only set the transfer error bit.
    if (any_err && (state == ST_RUN || state == ST_FIRST)) begin
      next_ae_pend = 1'b1;
    end
    if (any_err) begin
      next_xfer[XFER_ERR] = 1'b1;
    end

    case (state)
      ST_INIT: begin
        next_vbr = VBR_RST;
        next_exr[EXR_T] = 1'b0;
        next_exr[2:0] = MASK_MAX;
        next_ccr[CCR_I] = 1'b1;
        next_mode = MODE0;
        next_halt_a = HALTA_RST;
        next_halt_b = HALTB_RST;
        next_int_allow = 1'b0;
        next_mem_req = 1'b1;
        next_mem_we = 1'b0;
        next_mem_addr = VO_RESET;
        next_state = ST_VFETCH;
      end
      ST_VFETCH: begin
        if (mem_done) begin
          next_mem_req = 1'b0;
          next_pc_load = 1'b1;
          next_pc_value = mem_rdata;
          next_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        // The first instruction is expected to set the stack pointer.
        next_int_allow = 1'b0;
        if (retire.done) begin
          next_int_allow = 1'b1;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (retire.done && (next_ae_pend || do_trace)) begin
          next_save_pc = retire.next_pc;
          next_save_sr = {cond_code_reg, extended_ctrl_reg};
          next_ccr[CCR_I] = 1'b1;
          if (mode == MODE2) begin
            next_exr[EXR_T] = 1'b0;
          end
          if (next_ae_pend) begin
            next_ae_pend = 1'b0;
            if (mode == MODE2) begin
              next_exr[2:0] = MASK_MAX;
            end
            next_vec_addr = VO_ADDR_ERR;
          end else begin
            next_vec_addr = vector_base_reg + VO_TRACE;
          end
          // Odd stack pointers are not caught here; stacked values are then garbage.
          next_mem_req = 1'b1;
          next_mem_we = 1'b1;
          next_mem_addr = stack_ptr - STK_PC_OFS;
          next_mem_wdata = retire.next_pc;
          next_int_allow = 1'b0;
          next_state = ST_STK_PC;
        end
      end
      ST_STK_PC: begin
        if (mem_done) begin
          next_mem_addr = stack_ptr - STK_SR_OFS;
          next_mem_wdata = {16'h0000, save_sr};
          next_state = ST_STK_SR;
        end
      end
      ST_STK_SR: begin
        if (mem_done) begin
          next_mem_we = 1'b0;
          next_mem_addr = vec_addr;
          next_state = ST_EVEC;
        end
      end
      ST_EVEC: begin
        if (mem_done) begin
          next_mem_req = 1'b0;
          next_pc_load = 1'b1;
          next_pc_value = mem_rdata;
          next_sp_load = 1'b1;
          next_sp_value = stack_ptr - STK_SR_OFS;
          // Handlers, trace ones included, may take interrupts again.
          next_int_allow = 1'b1;
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_INIT;
        next_mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_INIT;
      vector_base_reg <= VBR_RST;
      cond_code_reg <= 8'h80;
      extended_ctrl_reg <= 8'h07;
      mode <= MODE0;
      module_halt_ctrl_a <= HALTA_RST;
      module_halt_ctrl_b <= HALTB_RST;
      transfer_ctrl_reg <= 8'h00;
      ae_pend <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      pc_load <= 1'b0;
      pc_value <= 32'h0000_0000;
      sp_load <= 1'b0;
      sp_value <= 32'h0000_0000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      int_allow <= 1'b0;
      int_pending <= 1'b0;
      pa_grant <= 1'b0;
      save_pc <= 32'h0000_0000;
      save_sr <= 16'h0000;
      vec_addr <= 32'h0000_0000;
      xfer_halt <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      vector_base_reg <= next_vbr;
      cond_code_reg <= next_ccr;
      extended_ctrl_reg <= next_exr;
      mode <= next_mode;
      module_halt_ctrl_a <= next_halt_a;
      module_halt_ctrl_b <= next_halt_b;
      transfer_ctrl_reg <= next_xfer;
      ae_pend <= next_ae_pend;
      reg_rdata <= next_rdata;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      sp_load <= next_sp_load;
      sp_value <= next_sp_value;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      int_allow <= next_int_allow;
      int_pending <= next_int_pending;
      pa_grant <= next_pa_grant;
      save_pc <= next_save_pc;
      save_sr <= next_save_sr;
      vec_addr <= next_vec_addr;
      xfer_halt <= next_xfer[XFER_ERR];
    end
  end
endmodule : ces_sequencer
`default_nettype wire

/* bench/ces_sequencer_props.sv */
// Concurrent checks on the exception sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module ces_sequencer_props
  import ces_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Core side.
  input wire ces_retire_t retire,
  input wire logic [31:0] stack_ptr,
  input wire ces_cycle_t cpu_cyc,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic sp_load,
  input wire logic [31:0] sp_value,
  // Memory side.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Interrupts, gate and status.
  input wire logic int_allow,
  input wire logic int_pending,
  input wire logic [4:0] pa_sel,
  input wire logic pa_req,
  input wire logic pa_grant,
  input wire logic [7:0] cond_code_reg,
  input wire logic [7:0] extended_ctrl_reg,
  input wire logic [15:0] module_halt_ctrl_a,
  input wire logic [15:0] module_halt_ctrl_b,
  input wire logic xfer_halt
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  chk_reset_values: assert property ($rose(nrst) |->
    module_halt_ctrl_a == HALTA_RST && module_halt_ctrl_b == HALTB_RST
    && cond_code_reg[CCR_I] && extended_ctrl_reg == 8'h07)
    else $error("reset values wrong");
  chk_pc_from_ack: assert property (pc_load |-> $past(mem_ack && !mem_we)
    && pc_value == $past(mem_rdata)) else $error("pc not from vector read");
  chk_mem_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
    else $error("memory request dropped");
  chk_int_gate: assert property (int_pending |-> $past(int_allow))
    else $error("interrupt pending while refused");
  chk_int_reopen: assert property ($rose(int_allow) |->
    $past(retire.done) || pc_load) else $error("interrupts opened without cause");
  chk_stack_first: assert property ($rose(mem_req) && mem_we |->
    mem_addr == stack_ptr - STK_PC_OFS && !int_allow && cond_code_reg[CCR_I])
    else $error("bad first stacking write");
  chk_sp_entry: assert property (sp_load |->
    pc_load && sp_value == stack_ptr - STK_SR_OFS) else $error("bad stack pointer after entry");
  chk_grant_cause: assert property (pa_grant |->
    $past(pa_req) && !$past(pa_sel[4])) else $error("grant without valid request");
  chk_fault_flag: assert property (int_allow && cpu_cyc.valid
    && cpu_cyc.kind == CES_FETCH && cpu_cyc.addr[0] |-> ##[1:3] xfer_halt)
    else $error("fault flag not set");
  cover property (sp_load);
  cover property ($rose(int_allow));
  cover property (pa_grant);
endmodule : ces_sequencer_props
bind ces_sequencer ces_sequencer_props u_props (.mclk, .nrst, .retire, .stack_ptr, .cpu_cyc,
  .pc_load, .pc_value, .sp_load, .sp_value, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .mem_rdata, .mem_ack, .int_allow, .int_pending, .pa_sel, .pa_req, .pa_grant, .cond_code_reg,
  .extended_ctrl_reg, .module_halt_ctrl_a, .module_halt_ctrl_b, .xfer_halt);
`default_nettype wire

/* bench/ces_mem_model.sv */
// Vector table and stack memory model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module ces_mem_model (
  // Clock, reset and pace.
  input wire logic mclk,
  input wire logic nrst,
  input wire logic slow,
  // Memory port.
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [1:0] wait_cnt;
  logic [63:0] wlog[$];
  // Read data is valid only in the acknowledge cycle; otherwise it toggles so stale use shows.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_cnt == {slow, 1'b0}) begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'h0;
      mem_rdata <= mem_addr ^ 32'h5a00_0000;
      if (mem_we) wlog.push_back({mem_addr, mem_wdata});
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : ces_mem_model
`default_nettype wire

/* bench/ces_sequencer_tb.sv */
// Self-checking testbench of the exception sequencer.
`timescale 1ns/1ps
`default_nettype none
module ces_sequencer_tb
  import ces_pkg::*;
;
  logic mclk, nrst, ce, reg_wr, reg_rd, single_chip, nmi, pa_b, pa_req, slow;
  logic pc_load, sp_load, mem_req, mem_we, mem_ack, int_allow, int_pending, pa_grant, xfer_halt;
  logic [3:0] reg_addr;
  logic [4:0] pa_sel;
  logic [7:0] rte_ccr, rte_exr, cond_code_reg, extended_ctrl_reg;
  logic [15:0] module_halt_ctrl_a, module_halt_ctrl_b;
  logic [31:0] reg_wdata, reg_rdata, stack_ptr, pc_value, sp_value, mem_addr, mem_wdata, mem_rdata;
  logic [N_EXT-1:0] ext_int_lines;
  logic [N_PERIPH-1:0] periph_int;
  ces_retire_t retire;
  ces_cycle_t cpu_cyc, xfer_cyc;
  int n_mismatch, cmp_count, i;
  int sh[4] = '{68, 60, 0, 69};
  ces_sequencer u_ces_sequencer (.mclk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .retire, .rte_ccr, .rte_exr, .stack_ptr, .cpu_cyc, .xfer_cyc, .single_chip,
    .pc_load, .pc_value, .sp_load, .sp_value, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .nmi, .ext_int_lines, .periph_int, .int_allow, .int_pending, .pa_sel,
    .pa_b, .pa_req, .pa_grant, .cond_code_reg, .extended_ctrl_reg, .module_halt_ctrl_a,
    .module_halt_ctrl_b, .xfer_halt);
  ces_mem_model u_ces_mem_model (.mclk, .nrst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task summarize;
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, "register read");
  endtask : rd
  task pa(input logic [4:0] s, input logic b, input logic exp);
    @(posedge mclk);
    pa_req <= 1'b1;
    pa_sel <= s;
    pa_b <= b;
    @(posedge mclk);
    pa_req <= 1'b0;
    #1 chk(pa_grant, exp, "peripheral grant");
  endtask : pa
  task retire_one(input logic r, input logic [31:0] pc);
    @(posedge mclk);
    retire <= {1'b1, r, pc};
    @(posedge mclk);
    retire <= '0;
    #1;
  endtask : retire_one
  task wait_pc(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (pc_load !== 1'b1 && n < 60);
    // A missed load would otherwise pass on the value left by an earlier entry.
    chk(pc_load, 1'b1, "program counter load");
    chk(pc_value, exp, "program counter");
  endtask : wait_pc
  task chk_stk(input logic [31:0] pc, input logic [31:0] st);
    chk(u_ces_mem_model.wlog[0], {stack_ptr - 32'h4, pc}, "stacked pc");
    chk(u_ces_mem_model.wlog[1], {stack_ptr - 32'h8, st}, "stacked status");
    u_ces_mem_model.wlog.delete();
  endtask : chk_stk
  task ae(input logic xf, input logic [1:0] k, input logic sc, input logic [23:0] a, input logic e);
    wr(RA_XFER, 32'h0);
    single_chip <= sc;
    stack_ptr <= {8'h0, a};
    if (xf) xfer_cyc <= {1'b1, k, a};
    else cpu_cyc <= {1'b1, k, a};
    @(posedge mclk);
    cpu_cyc <= '0;
    xfer_cyc <= '0;
    repeat (3) @(posedge mclk);
    #1 chk(xfer_halt, e, "fault flag");
  endtask : ae
  initial begin
    repeat (4000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {nrst, reg_wr, reg_rd, single_chip, pa_b, pa_req, slow, pa_sel, reg_addr} = '0;
    {reg_wdata, rte_ccr, rte_exr, retire, cpu_cyc, xfer_cyc, ext_int_lines, periph_int} = '0;
    {ce, nmi, stack_ptr} = {2'h3, 32'h0};
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    wait_pc(32'h5a00_0000);
    chk(int_allow, 1'b0, "early interrupt");
    chk({cond_code_reg, extended_ctrl_reg}, 16'h8007, "status outputs");
    chk({module_halt_ctrl_a, module_halt_ctrl_b}, {HALTA_RST, HALTB_RST}, "halts");
    rd(RA_VBR, VBR_RST);
    rd(RA_CCR, 32'h80);
    rd(RA_EXR, 32'h07);
    rd(RA_HALTA, {16'h0, HALTA_RST});
    rd(RA_HALTB, {16'h0, HALTB_RST});
    rd(RA_MODE, 32'h0);
    rd(4'hf, 32'h0);
    chk(int_pending, 1'b0, "nmi refused");
    @(posedge mclk);
    stack_ptr <= 32'h0000_1000;
    retire_one(1'b0, 32'h100);
    repeat (2) @(posedge mclk);
    #1 chk(int_pending, 1'b1, "nmi taken");
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      {nmi, ext_int_lines, periph_int} <= 69'h1 << sh[i];
      repeat (3) @(posedge mclk);
      #1 chk(int_pending, i < 3, "source");
    end
    $display("test reset and sources done");
    pa(5'h00, 1'b0, 1'b0);
    pa(5'h0c, 1'b0, 1'b1);
    pa(5'h03, 1'b1, 1'b0);
    wr(RA_HALTA, 32'h0000_0ffe);
    pa(5'h00, 1'b0, 1'b1);
    pa(5'h10, 1'b0, 1'b0);
    $display("test peripheral gate done");
    wr(RA_EXR, 32'h80);
    retire_one(1'b0, 32'h104);
    chk(mem_req, 1'b0, "no trace in mode 0");
    wr(RA_EXR, 32'h0);
    wr(RA_MODE, 32'h2);
    wr(RA_MODE, 32'h3);
    rd(RA_MODE, 32'h2);
    wr(RA_VBR, 32'h100);
    wr(RA_EXR, 32'h80);
    wr(RA_CCR, 32'h80);
    retire_one(1'b0, 32'h200);
    chk(mem_req, 1'b1, "trace entry");
    wait_pc(32'h5a00_0114);
    chk(sp_load, 1'b1, "stack pointer load");
    chk(sp_value, 32'h0ff8, "stack pointer");
    chk_stk(32'h200, 32'h8080);
    rd(RA_EXR, 32'h0);
    chk(int_allow, 1'b1, "service routine");
    @(posedge mclk);
    {rte_ccr, rte_exr} <= 16'h0080;
    retire_one(1'b1, 32'h204);
    chk(mem_req, 1'b0, "return not traced");
    rd(RA_EXR, 32'h80);
    @(posedge mclk);
    slow <= 1'b1;
    retire_one(1'b0, 32'h208);
    wait_pc(32'h5a00_0114);
    chk_stk(32'h208, 32'h0080);
    $display("test trace done");
    @(posedge mclk);
    ce <= 1'b0;
    wr(RA_CCR, 32'h0);
    ce <= 1'b1;
    rd(RA_CCR, 32'h80);
    $display("test clock enable done");
    @(posedge mclk);
    cpu_cyc <= {1'b1, CES_FETCH, 24'h000301};
    @(posedge mclk);
    cpu_cyc <= '0;
    retire_one(1'b0, 32'h300);
    @(posedge mclk);
    cpu_cyc <= {1'b1, CES_FETCH, 24'h000401};
    @(posedge mclk);
    cpu_cyc <= '0;
    wait_pc(VO_ADDR_ERR ^ 32'h5a00_0000);
    chk_stk(32'h300, 32'h8000);
    rd(RA_STAT, 32'h12);
    rd(RA_CCR, 32'h80);
    rd(RA_EXR, 32'h07);
    chk(xfer_halt, 1'b1, "fault on error");
    $display("test address error entry done");
    ae(1'b0, 2'h0, 1'b0, 24'h001000, 1'b0);
    ae(1'b0, 2'h0, 1'b0, 24'h001001, 1'b1);
    ae(1'b0, 2'h0, 1'b0, 24'hff0010, 1'b1);
    ae(1'b0, 2'h0, 1'b1, 24'h400000, 1'b1);
    ae(1'b0, 2'h0, 1'b0, 24'h400000, 1'b0);
    ae(1'b0, 2'h0, 1'b0, 24'hf00000, 1'b1);
    ae(1'b0, 2'h1, 1'b0, 24'h000ffe, 1'b0);
    ae(1'b0, 2'h1, 1'b0, 24'h000fff, 1'b1);
    ae(1'b0, 2'h2, 1'b0, 24'h001001, 1'b0);
    ae(1'b1, 2'h2, 1'b0, 24'h001001, 1'b0);
    ae(1'b0, 2'h2, 1'b1, 24'h400000, 1'b1);
    ae(1'b1, 2'h2, 1'b1, 24'h400001, 1'b1);
    ae(1'b1, 2'h2, 1'b0, 24'hf00000, 1'b1);
    $display("test address error sources done");
    summarize();
  end
endmodule : ces_sequencer_tb
`default_nettype wire
